// ===== sw_slot_slave.sv
/*
 * Slave end of the slot link: answers reset with presence unless the command buffer is full, times write
 * samples and read-zero pulldowns from each fall seen while idle or in recovery, and buffers the
 * command byte in two entries.
 * Assumes one master and a same-clock user of resp_en and resp_bit.
 */
// Notes on behaviour
// RULE1 - master starts slots; slave drives presence, read-zero
// RULE2 - reset and presence precede any command
// RULE3 - after reset release wait, then presence low
// RULE4 - master samples presence at fixed time
// RULE5 - one bit per time slot
// RULE6 - slot timer starts at each falling edge; the slave starts it only on a fall in S_IDLE or S_REC
// RULE7 - write-one low ends before its maximum
// RULE8 - write-zero low lasts at least its minimum
// RULE9 - recovery time needed before next slot
// RULE10 - read slot starts like write-one
// RULE11 - read zero pulls low, read one silent
// RULE12 - master samples read bit inside window
// RULE13 - master waits full slot before next
// RULE14 - bus idles high, never paused low
// RULE15 - no new sequence before reset high expires
// RULE16 - commands are eight bits; unsupported stay silent
// RULE17 - overlong low aborts slot, becomes reset
// RULE18 - reset low between minimum and maximum
`timescale 1ns/1ps
module sw_slot_slave
   import sw_link_pkg::*;
#(
   parameter logic [CNT_W-1:0] DETECT_CYC  = RESET_DETECT_CYC,
   parameter logic [CNT_W-1:0] SAMPLE_CYC  = SLAVE_SAMPLE_CYC,
   parameter logic [CNT_W-1:0] HOLD_CYC    = SLAVE_HOLD_CYC,
   parameter logic [CNT_W-1:0] PD_WAIT_CYC = PRESENCE_WAIT_CYC,
   parameter logic [CNT_W-1:0] PD_LOW_CYC  = PRESENCE_LOW_CYC,
   parameter logic [CNT_W-1:0] REC_CYC     = SLOT_RECOVERY_CYC
) (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // received command byte
   output logic [7:0]      cmd_data,
   output logic            cmd_valid,
   input  wire logic       cmd_ready,
   // read-slot answer
   input  wire logic       resp_en,
   input  wire logic       resp_bit,
   output logic            resp_taken,
   // status
   output logic            bus_reset,
   // line
   sw_link_if.slave        link
);
   import sw_link_pkg::*;

   typedef enum {S_IDLE, S_SLOT, S_RESET, S_PD_WAIT, S_PD_LOW, S_REC}
      s_state_e;

   // ---------------------------------------------------------------
   // line synchroniser and edge detect
   // ---------------------------------------------------------------
   logic             meta_q;
   logic             line_q;
   logic             prev_q;
   logic             fall;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= 1'b1;
         line_q <= 1'b1;
         prev_q <= 1'b1;
      end else begin
         meta_q <= link.line;
         line_q <= meta_q;
         prev_q <= line_q;
      end
   end

   assign fall = prev_q && !line_q;   // RULE6

   // ---------------------------------------------------------------
   // slot timer and state
   // ---------------------------------------------------------------
   s_state_e         state_q;
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_inc;
   logic             oe_q;
   logic             armed_q;
   logic             got_q;
   logic [2:0]       bits_q;
   logic [7:0]       shift_q;
   logic             push_q;
   logic [7:0]       push_d_q;
   logic             resp_slot_q;
   logic             resp_taken_q;
   logic             bus_reset_q;
   logic             buf_ready;
   logic             answer_zero;
   logic             at_sample;
   logic             slot_done;
   logic             long_low;

   assign cnt_inc     = cnt_q + 1'b1;
   // silent until a command has been taken in
   assign answer_zero = got_q && resp_en && !resp_bit;   // RULE11 RULE16
   assign at_sample   = (cnt_q == SAMPLE_CYC) && armed_q;   // RULE5
   // slot over once the line is back high and we have sampled
   assign slot_done   = line_q && !oe_q && (cnt_q > SAMPLE_CYC);
   assign long_low    = !line_q && (cnt_q >= DETECT_CYC);   // RULE17

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q      <= S_IDLE;
         cnt_q        <= '0;
         oe_q         <= 1'b0;
         armed_q      <= 1'b0;
         got_q        <= 1'b0;
         bits_q       <= 3'h0;
         shift_q      <= 8'h00;
         push_q       <= 1'b0;
         push_d_q     <= 8'h00;
         resp_slot_q  <= 1'b0;
         resp_taken_q <= 1'b0;
         bus_reset_q  <= 1'b0;
      end else begin
         push_q       <= 1'b0;
         resp_taken_q <= 1'b0;
         bus_reset_q  <= 1'b0;
         unique case (state_q)
            S_IDLE, S_REC: begin
               if (fall) begin
                  state_q     <= S_SLOT;   // RULE6
                  cnt_q       <= '0;
                  oe_q        <= answer_zero;   // RULE1 RULE11
                  resp_slot_q <= got_q && resp_en;
               end else if (state_q == S_REC) begin
                  // recovery only counts while the line is high
                  cnt_q <= line_q ? cnt_inc : '0;   // RULE9
                  if (line_q && cnt_inc >= REC_CYC) begin
                     state_q <= S_IDLE;
                  end
               end
            end
            S_SLOT: begin
               cnt_q <= cnt_inc;
               if (cnt_q == HOLD_CYC) begin
                  oe_q <= 1'b0;   // RULE11
               end
               if (at_sample) begin
                  shift_q <= {line_q, shift_q[7:1]};   // RULE5
                  bits_q  <= bits_q + 3'h1;
                  if (bits_q == 3'h7) begin
                     push_q   <= 1'b1;   // RULE16
                     push_d_q <= {line_q, shift_q[7:1]};
                     armed_q  <= 1'b0;
                     got_q    <= 1'b1;   // RULE16
                  end
               end
               if (long_low) begin
                  state_q     <= S_RESET;   // RULE17
                  oe_q        <= 1'b0;
                  armed_q     <= 1'b0;
                  got_q       <= 1'b0;
                  bus_reset_q <= 1'b1;
               end else if (slot_done) begin
                  state_q      <= S_REC;   // RULE9
                  cnt_q        <= '0;
                  resp_taken_q <= resp_slot_q;
               end
            end
            S_RESET: begin
               // a full buffer withholds presence: not ready for a command
               if (line_q) begin
                  state_q <= buf_ready ? S_PD_WAIT : S_REC;   // RULE2
                  cnt_q   <= '0;
               end
            end
            S_PD_WAIT: begin
               cnt_q <= cnt_inc;
               if (cnt_inc >= PD_WAIT_CYC) begin
                  state_q <= S_PD_LOW;   // RULE3
                  cnt_q   <= '0;
                  oe_q    <= 1'b1;
               end
            end
            S_PD_LOW: begin
               cnt_q <= cnt_inc;
               if (cnt_inc >= PD_LOW_CYC) begin
                  state_q <= S_REC;   // RULE3
                  cnt_q   <= '0;
                  oe_q    <= 1'b0;
                  armed_q <= 1'b1;   // RULE2
                  bits_q  <= 3'h0;
               end
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // two-entry command buffer
   // ---------------------------------------------------------------
   logic             out_v_q;
   logic [7:0]       out_d_q;
   logic             spare_v_q;
   logic [7:0]       spare_d_q;
   logic             advance;

   assign buf_ready = !spare_v_q;
   assign advance   = !out_v_q || cmd_ready;

   // the spare entry catches a byte while the user stalls
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         out_v_q   <= 1'b0;
         out_d_q   <= 8'h00;
         spare_v_q <= 1'b0;
         spare_d_q <= 8'h00;
      end else if (advance && spare_v_q) begin
         out_v_q   <= 1'b1;
         out_d_q   <= spare_d_q;
         spare_v_q <= push_q;
         spare_d_q <= push_d_q;
      end else if (advance) begin
         out_v_q <= push_q;
         out_d_q <= push_d_q;
      end else if (push_q) begin
         spare_v_q <= 1'b1;
         spare_d_q <= push_d_q;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign cmd_valid       = out_v_q;
   assign cmd_data        = out_d_q;
   assign resp_taken      = resp_taken_q;
   assign bus_reset       = bus_reset_q;
   assign link.slave_oe   = oe_q;   // RULE1
   assign link.slave_out  = 1'b0;

endmodule

// ===== sw_link_pkg.sv
/*
 * Timing figures, counter width and master operations for both ends.
 * Assumes a 250 MHz clock and a pulled-up open-drain line.
 */
package sw_link_pkg;

   // ---------------------------------------------------------------
   // clock and counter width
   // ---------------------------------------------------------------
   localparam int CLK_MHZ = 250;
   localparam int CNT_W   = 20;

   // least times round up, longest times round down
   function automatic int cyc_min(input int ns);
      return (ns * CLK_MHZ + 999) / 1000;
   endfunction

   function automatic int cyc_max(input int ns);
      return (ns * CLK_MHZ) / 1000;
   endfunction

   // ---------------------------------------------------------------
   // times in ns
   // ---------------------------------------------------------------
   localparam int RESET_LOW_NS          = 480000;
   localparam int RESET_HIGH_NS         = 480000;
   localparam int RESET_DETECT_NS       = 440000;
   localparam int PRESENCE_WAIT_TIME_NS = 30000;
   localparam int PRESENCE_LOW_TIME_NS  = 120000;
   localparam int PRESENCE_SAMPLE_NS    = 70000;
   localparam int WRITE_ONE_LOW_NS      = 6000;
   localparam int WRITE_ZERO_LOW_MIN_NS = 60000;
   localparam int READ_LOW_TIME_NS      = 6000;
   localparam int READ_SAMPLE_NS        = 13000;
   localparam int SLOT_DURATION_NS      = 70000;
   localparam int SLOT_RECOVERY_NS      = 5000;
   localparam int SLAVE_SAMPLE_NS       = 30000;
   localparam int SLAVE_HOLD_NS         = 20000;

   // ---------------------------------------------------------------
   // counts in clock cycles
   // ---------------------------------------------------------------
   localparam logic [CNT_W-1:0] RESET_LOW_CYC =
      CNT_W'(cyc_min(RESET_LOW_NS));
   localparam logic [CNT_W-1:0] RESET_HIGH_CYC =
      CNT_W'(cyc_min(RESET_HIGH_NS));
   localparam logic [CNT_W-1:0] RESET_DETECT_CYC =
      CNT_W'(cyc_min(RESET_DETECT_NS));
   localparam logic [CNT_W-1:0] PRESENCE_WAIT_CYC =
      CNT_W'(cyc_min(PRESENCE_WAIT_TIME_NS));
   localparam logic [CNT_W-1:0] PRESENCE_LOW_CYC =
      CNT_W'(cyc_min(PRESENCE_LOW_TIME_NS));
   localparam logic [CNT_W-1:0] PRESENCE_SAMPLE_CYC =
      CNT_W'(cyc_max(PRESENCE_SAMPLE_NS));
   localparam logic [CNT_W-1:0] WRITE_ONE_LOW_CYC =
      CNT_W'(cyc_max(WRITE_ONE_LOW_NS));
   localparam logic [CNT_W-1:0] WRITE_ZERO_LOW_CYC =
      CNT_W'(cyc_min(WRITE_ZERO_LOW_MIN_NS));
   localparam logic [CNT_W-1:0] READ_LOW_CYC =
      CNT_W'(cyc_max(READ_LOW_TIME_NS));
   localparam logic [CNT_W-1:0] READ_SAMPLE_CYC =
      CNT_W'(cyc_max(READ_SAMPLE_NS));
   localparam logic [CNT_W-1:0] SLOT_DURATION_CYC =
      CNT_W'(cyc_min(SLOT_DURATION_NS));
   localparam logic [CNT_W-1:0] SLOT_RECOVERY_CYC =
      CNT_W'(cyc_min(SLOT_RECOVERY_NS));
   localparam logic [CNT_W-1:0] SLAVE_SAMPLE_CYC =
      CNT_W'(cyc_min(SLAVE_SAMPLE_NS));
   localparam logic [CNT_W-1:0] SLAVE_HOLD_CYC =
      CNT_W'(cyc_min(SLAVE_HOLD_NS));

   // ---------------------------------------------------------------
   // master operations
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      OP_RESET,
      OP_WRITE0,
      OP_WRITE1,
      OP_READ
   } op_e;

endpackage

// ===== sw_link_if.sv
/*
 * The open-drain line between master and slave ends.
 * Assumes each end only pulls low; the pullup is a wired-AND.
 */
`timescale 1ns/1ps
interface sw_link_if;
   logic master_out;
   logic master_oe;
   logic slave_out;
   logic slave_oe;
   logic line;

   // ---------------------------------------------------------------
   // low whenever either end pulls
   // ---------------------------------------------------------------
   assign line = !((master_oe && !master_out) || (slave_oe && !slave_out));

   modport master (output master_out, output master_oe, input line);
   modport slave  (output slave_out, output slave_oe, input line);
endinterface

// ===== sw_slot_master.sv
/*
 * Master end of the slot link: makes reset pulses and write and read
 * slots on request, samples presence and read bits, and spaces slots.
 * Assumes requests come from logic on the same clock.
 */
`timescale 1ns/1ps
module sw_slot_master
   import sw_link_pkg::*;
#(
   parameter logic [CNT_W-1:0] RST_LOW_CYC  = RESET_LOW_CYC,
   parameter logic [CNT_W-1:0] RST_HIGH_CYC = RESET_HIGH_CYC,
   parameter logic [CNT_W-1:0] PD_SMP_CYC   = PRESENCE_SAMPLE_CYC,
   parameter logic [CNT_W-1:0] W1_LOW_CYC   = WRITE_ONE_LOW_CYC,
   parameter logic [CNT_W-1:0] W0_LOW_CYC   = WRITE_ZERO_LOW_CYC,
   parameter logic [CNT_W-1:0] RD_LOW_CYC   = READ_LOW_CYC,
   parameter logic [CNT_W-1:0] RD_SMP_CYC   = READ_SAMPLE_CYC,
   parameter logic [CNT_W-1:0] SLOT_CYC     = SLOT_DURATION_CYC,
   parameter logic [CNT_W-1:0] REC_CYC      = SLOT_RECOVERY_CYC
) (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // requests
   input  wire logic       req_valid,
   input  wire op_e        req_op,
   output logic            req_ready,
   // results
   output logic            rsp_valid,
   output logic            rsp_bit,
   // line
   sw_link_if.master       link
);
   import sw_link_pkg::*;

   typedef enum {M_IDLE, M_BUSY} m_state_e;

   // ---------------------------------------------------------------
   // line synchroniser
   // ---------------------------------------------------------------
   logic             meta_q;
   logic             line_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= 1'b1;
         line_q <= 1'b1;
      end else begin
         meta_q <= link.line;
         line_q <= meta_q;
      end
   end

   // ---------------------------------------------------------------
   // per-operation timing selection
   // ---------------------------------------------------------------
   m_state_e         state_q;
   op_e              op_q;
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_inc;
   logic [CNT_W-1:0] low_end;
   logic [CNT_W-1:0] smp_pt;
   logic [CNT_W-1:0] last;
   logic             is_rst;
   logic             samples;

   assign cnt_inc = cnt_q + 1'b1;
   assign is_rst  = (op_q == OP_RESET);
   assign samples = is_rst || (op_q == OP_READ);
   // low lengths: write-one short, write-zero long, read short
   assign low_end = is_rst              ? RST_LOW_CYC :   // RULE18
                    (op_q == OP_WRITE0) ? W0_LOW_CYC :    // RULE8
                    (op_q == OP_WRITE1) ? W1_LOW_CYC :    // RULE7
                                          RD_LOW_CYC;     // RULE10
   assign smp_pt  = is_rst ? CNT_W'(RST_LOW_CYC + PD_SMP_CYC)   // RULE4
                           : RD_SMP_CYC;                        // RULE12
   // full slot plus recovery, or reset low plus full reset high time
   assign last    = is_rst ? CNT_W'(RST_LOW_CYC + RST_HIGH_CYC - 1'b1)
                           : CNT_W'(SLOT_CYC + REC_CYC - 1'b1);  // RULE13

   // ---------------------------------------------------------------
   // slot sequencer
   // ---------------------------------------------------------------
   logic             oe_q;
   logic             ready_q;
   logic             rsp_valid_q;
   logic             rsp_bit_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q     <= M_IDLE;
         op_q        <= OP_RESET;
         cnt_q       <= '0;
         oe_q        <= 1'b0;
         ready_q     <= 1'b0;
         rsp_valid_q <= 1'b0;
         rsp_bit_q   <= 1'b0;
      end else begin
         rsp_valid_q <= 1'b0;
         unique case (state_q)
            M_IDLE: begin
               // line stays released between requests
               ready_q <= 1'b1;   // RULE14
               if (req_valid && ready_q) begin
                  state_q <= M_BUSY;   // RULE1 RULE5
                  op_q    <= req_op;
                  cnt_q   <= '0;
                  oe_q    <= 1'b1;
                  ready_q <= 1'b0;
               end
            end
            M_BUSY: begin
               cnt_q <= cnt_inc;
               oe_q  <= (cnt_inc < low_end);
               if (samples && cnt_q == smp_pt) begin
                  rsp_bit_q <= is_rst ? !line_q : line_q;   // RULE4 RULE12
               end
               // no new request until slot, recovery or reset high ends
               if (cnt_q == last) begin
                  state_q     <= M_IDLE;   // RULE9 RULE15
                  rsp_valid_q <= 1'b1;
                  ready_q     <= 1'b1;
               end
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign req_ready       = ready_q;
   assign rsp_valid       = rsp_valid_q;
   assign rsp_bit         = rsp_bit_q;
   assign link.master_oe  = oe_q;
   assign link.master_out = 1'b0;

endmodule

// ===== single_wire_slot_signaling_assertions.sv
/*
 * Checks on the single-wire link joining master and slave ends.
 * Assumes the counts of the ends it watches.
 */
`timescale 1ns/1ps
module single_wire_slot_signaling_assertions
   import sw_link_pkg::*;
#(
   parameter logic [CNT_W-1:0] PD_WAIT = 20'h1E,
   parameter logic [CNT_W-1:0] PD_LOW  = 20'h3C,
   parameter logic [CNT_W-1:0] HOLD    = 20'h14,
   parameter logic [CNT_W-1:0] W1_LOW  = 20'h6,
   parameter logic [CNT_W-1:0] W0_LOW  = 20'h3C,
   parameter logic [CNT_W-1:0] RST_LOW = 20'h12C,
   parameter logic [CNT_W-1:0] SLOT    = 20'h46,
   parameter logic [CNT_W-1:0] REC     = 20'h5,
   parameter logic [CNT_W-1:0] DETECT  = 20'hC8
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // link signals
   input wire logic master_out,
   input wire logic master_oe,
   input wire logic slave_out,
   input wire logic slave_oe,
   input wire logic line
);
   localparam logic [CNT_W-1:0] TOP = {CNT_W{1'b1}};

   // ---------------------------------------------------------------
   // run lengths
   // ---------------------------------------------------------------
   logic [CNT_W-1:0] hi_q;
   logic [CNT_W-1:0] lo_q;
   logic [CNT_W-1:0] m_q;
   logic [CNT_W-1:0] s_q;
   logic [CNT_W-1:0] g_q;
   logic             m_rise;

   assign m_rise = master_oe && (m_q == '0);

   // preset high run and gap: first slot after reset is not early
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hi_q <= TOP;
         lo_q <= '0;
         m_q  <= '0;
         s_q  <= '0;
         g_q  <= TOP;
      end else begin
         hi_q <= line ? hi_q + CNT_W'(hi_q != TOP) : '0;
         lo_q <= line ? '0 : lo_q + 20'h1;
         m_q  <= master_oe ? m_q + 20'h1 : '0;
         s_q  <= slave_oe ? s_q + 20'h1 : '0;
         g_q  <= m_rise ? '0 : g_q + CNT_W'(g_q != TOP);
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   a_master_drain_only: assert property (master_out == 1'b0)
      else $error("master drives the line high");
   a_slave_drain_only: assert property (slave_out == 1'b0)
      else $error("slave drives the line high");
   a_presence_wait: assert property ($rose(slave_oe) && $past(line) |->
      $past(hi_q) inside {[PD_WAIT - 20'h1 : PD_WAIT + 20'h5]})
      else $error("presence started off its wait");
   a_pull_length: assert property ($fell(slave_oe) |->
      s_q inside {[PD_LOW - 20'h1 : PD_LOW + 20'h1], [HOLD : HOLD + 20'h2]})
      else $error("slave pulldown of wrong length");
   a_read_zero_window: assert property ($rose(slave_oe) && !$past(line)
      |-> $past(master_oe))
      else $error("read zero started outside read low");
   a_master_low_len: assert property ($fell(master_oe) |->
      m_q == W1_LOW || m_q == W0_LOW || m_q == RST_LOW)
      else $error("master low pulse of wrong length");
   a_master_not_stuck: assert property (m_q <= RST_LOW)
      else $error("master held the line low too long");
   a_slot_spacing: assert property ($rose(master_oe) |->
      $past(g_q) >= SLOT + REC - 20'h2)
      else $error("master slot started too early");
   a_recovery_high: assert property ($rose(master_oe) |->
      $past(hi_q) >= REC)
      else $error("recovery high too short");
   a_long_low_master: assert property (lo_q > DETECT |-> !slave_oe)
      else $error("slave holds a long low");

   c_presence: cover property ($rose(slave_oe) && $past(line));
   c_read_zero: cover property ($rose(slave_oe) && !$past(line));
   c_write_zero: cover property ($fell(master_oe) && m_q == W0_LOW);
endmodule

// ===== single_wire_slot_signaling_tb.sv
/*
 * Bench: master and slave on one link, a second slave on a hand-driven
 * link.
 * Assumes the shortened counts below.
 */
`timescale 1ns/1ps
module single_wire_slot_signaling_tb;
   import sw_link_pkg::*;

   // ---------------------------------------------------------------
   // shortened counts and bench state
   // ---------------------------------------------------------------
   localparam logic [CNT_W-1:0] DET = 20'hC8;
   localparam logic [CNT_W-1:0] PDW = 20'h1E;
   localparam logic [CNT_W-1:0] PDL = 20'h3C;
   localparam logic [CNT_W-1:0] HLD = 20'h14;
   localparam logic [CNT_W-1:0] REC = 20'h5;
   localparam logic [CNT_W-1:0] RSL = 20'h12C;
   localparam logic [CNT_W-1:0] W1L = 20'h6;
   localparam logic [CNT_W-1:0] W0L = 20'h3C;
   localparam logic [CNT_W-1:0] SLT = 20'h46;

   logic       clk       = 1'b0;
   logic       rst_n     = 1'b0;
   logic       req_valid = 1'b0;
   op_e        req_op    = OP_RESET;
   logic       cmd_ready = 1'b0;
   logic       resp_en   = 1'b0;
   logic       resp_bit  = 1'b0;
   logic       req_ready;
   logic       rsp_valid;
   logic       rsp_bit;
   logic [7:0] cmd_data;
   logic       cmd_valid;
   logic       resp_taken;
   logic       bus_reset;
   logic       bus_rst_b;
   int         fail_count = 0;
   int         num_checks = 0;
   int         n_rst      = 0;
   int         n_rst_b    = 0;
   int         n_taken    = 0;

   sw_link_if link ();
   sw_link_if link2 ();

   sw_slot_master #(.RST_LOW_CYC(RSL), .RST_HIGH_CYC(RSL), .PD_SMP_CYC(SLT),
      .W1_LOW_CYC(W1L), .W0_LOW_CYC(W0L), .RD_LOW_CYC(W1L),
      .RD_SMP_CYC(20'hD), .SLOT_CYC(SLT), .REC_CYC(REC)) u_sw_slot_master (
      .clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_op(req_op),
      .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_bit(rsp_bit),
      .link(link));
   sw_slot_slave #(.DETECT_CYC(DET), .SAMPLE_CYC(PDW), .HOLD_CYC(HLD),
      .PD_WAIT_CYC(PDW), .PD_LOW_CYC(PDL), .REC_CYC(REC)) u_sw_slot_slave (
      .clk(clk), .rst_n(rst_n), .cmd_data(cmd_data), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .resp_en(resp_en), .resp_bit(resp_bit),
      .resp_taken(resp_taken), .bus_reset(bus_reset), .link(link));
   // second slave, master side driven by hand
   sw_slot_slave #(.DETECT_CYC(DET), .SAMPLE_CYC(PDW), .HOLD_CYC(HLD),
      .PD_WAIT_CYC(PDW), .PD_LOW_CYC(PDL), .REC_CYC(REC)) u_sw_slot_slave_b (
      .clk(clk), .rst_n(rst_n), .cmd_data(), .cmd_valid(), .cmd_ready(1'b1),
      .resp_en(1'b0), .resp_bit(1'b1), .resp_taken(),
      .bus_reset(bus_rst_b), .link(link2));
   single_wire_slot_signaling_assertions #(.PD_WAIT(PDW), .PD_LOW(PDL),
      .HOLD(HLD), .W1_LOW(W1L), .W0_LOW(W0L), .RST_LOW(RSL), .SLOT(SLT),
      .REC(REC), .DETECT(DET)) u_checker (
      .clk(clk), .rst_n(rst_n), .master_out(link.master_out),
      .master_oe(link.master_oe), .slave_out(link.slave_out),
      .slave_oe(link.slave_oe), .line(link.line));

   // ---------------------------------------------------------------
   // clock and pulse counters
   // ---------------------------------------------------------------
   always #2 clk = ~clk;

   // count one-cycle pulses
   always @(posedge clk) begin
      n_rst   <= n_rst + int'(bus_reset === 1'b1);
      n_rst_b <= n_rst_b + int'(bus_rst_b === 1'b1);
      n_taken <= n_taken + int'(resp_taken === 1'b1);
   end

   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic chk(input string what, input logic [7:0] exp,
                      input logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // one master operation, negedge to negedge
   task automatic op(input op_e o, output logic b);
      int k;
      req_op    = o;
      req_valid = 1'b1;
      for (k = 0; k < 50 && req_ready !== 1'b1; k++)
         @(negedge clk);
      @(negedge clk);
      req_valid = 1'b0;
      for (; k < 1000 && rsp_valid !== 1'b1; k++)
         @(negedge clk);
      if (k == 1000) begin
         chk("op_done", 8'h01, 8'h00);
         end_of_test();
      end
      b = rsp_bit;
      @(negedge clk);
   endtask

   // bits leave least significant first
   task automatic send(input logic [7:0] v);
      logic b;
      for (int i = 0; i < 8; i++)
         op(v[i] ? OP_WRITE1 : OP_WRITE0, b);
   endtask

   task automatic pop(input logic [7:0] v);
      chk("cmd_valid", 8'h01, {7'h0, cmd_valid});
      chk("cmd_data", v, cmd_data);
      cmd_ready = 1'b1;
      @(negedge clk);
      cmd_ready = 1'b0;
      @(negedge clk);
   endtask

   task automatic pull(input int n);
      link2.master_oe = 1'b1;
      repeat (n) @(negedge clk);
      link2.master_oe = 1'b0;
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   // stalled consumer: two commands fill both entries
   task automatic t_fill;
      logic b;
      op(OP_RESET, b);
      chk("presence", 8'h01, {7'h0, b});
      chk("idle_line", 8'h01, {7'h0, link.line});
      send(8'h01);
      chk("cmd_data", 8'h01, cmd_data);
      op(OP_RESET, b);
      chk("presence", 8'h01, {7'h0, b});
      send(8'h80);
      chk("resets", 8'h02, 8'(n_rst));
   endtask

   task automatic t_read;
      logic b;
      resp_en = 1'b1;
      op(OP_READ, b);
      chk("read_zero", 8'h00, {7'h0, b});
      chk("answered", 8'h01, 8'(n_taken));
      resp_bit = 1'b1;
      op(OP_READ, b);
      chk("read_one", 8'h01, {7'h0, b});
   endtask

   // full buffer withholds presence; a read then stays silent
   task automatic t_refuse;
      logic b;
      resp_bit = 1'b0;
      op(OP_RESET, b);
      chk("presence", 8'h00, {7'h0, b});
      op(OP_READ, b);
      chk("silent", 8'h01, {7'h0, b});
      resp_en = 1'b0;
   endtask

   task automatic t_drain;
      logic b;
      pop(8'h01);
      pop(8'h80);
      chk("cmd_valid", 8'h00, {7'h0, cmd_valid});
      op(OP_RESET, b);
      chk("presence", 8'h01, {7'h0, b});
   endtask

   // long low, alone or in a slot, is a reset
   task automatic t_abort;
      pull(int'(DET) + 20);
      repeat (int'(PDW) + 15) @(negedge clk);
      chk("presence_b", 8'h00, {7'h0, link2.line});
      repeat (80) @(negedge clk);
      pull(3);
      repeat (2) @(negedge clk);
      pull(int'(DET) + 20);
      repeat (int'(PDW) + 15) @(negedge clk);
      chk("presence_b", 8'h00, {7'h0, link2.line});
      chk("resets_b", 8'h02, 8'(n_rst_b));
      repeat (80) @(negedge clk);
      chk("idle_b", 8'h01, {7'h0, link2.line});
   endtask

   initial begin
      link2.master_out = 1'b0;
      link2.master_oe  = 1'b0;
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      t_fill();
      t_read();
      t_refuse();
      t_drain();
      t_abort();
      end_of_test();
   end
endmodule
